// ===== bench/test_usb_otg_line_control_and_error_flags.sv
// Self-checking testbench for the USB line control and error flag block.
`timescale 1ns/1ps

module test_usb_otg_line_control_and_error_flags;
  import usbol_pkg::*;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  // A short turnaround limit keeps the run brief.
  localparam int TA_LIM = 2;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0]       wr_data = '0;
  logic              wr_stb = 1'b0;
  logic              rd_stb = 1'b0;
  logic [31:0]       rd_data;
  usbol_pull_s       hw_pull = '0;
  usbol_evt_s        evt;
  usbol_ta_s         ta;
  logic              xfer_busy = 1'b0;
  logic [6:0]        line_o;
  logic              pkt_reject;
  logic              irq;
  int                error_cnt = 0;
  int                comparisons = 0;

  // Clock at 20 MHz.
  always #25 clk = ~clk;

  usbol_peer i_peer (.clk(clk), .evt(evt), .ta(ta));

  usbol_top #(.TA_LIMIT(TA_LIM)) i_dut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .hw_pull(hw_pull), .evt(evt), .ta(ta),
    .xfer_busy(xfer_busy), .dplus_pullup_en(line_o[6]), .dminus_pullup_en(line_o[5]),
    .dplus_pulldown_en(line_o[4]), .dminus_pulldown_en(line_o[3]),
    .vbus_power_on(line_o[2]), .vbus_charge_en(line_o[1]),
    .vbus_discharge_en(line_o[0]), .pkt_reject(pkt_reject), .irq(irq));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The strobe is held over one edge only; the slave never stalls.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge.
  task automatic expect_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 check(what, exp, rd_data);
  endtask

  // Pull requests and busy are engine levels, changed just after an edge.
  task automatic set_pull(input logic [3:0] p, input logic busy);
    @(posedge clk);
    hw_pull <= p;
    xfer_busy <= busy;
  endtask

  task automatic test_done();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Reset values, and an unmapped address that must not alias.
  task automatic t_reset();
    expect_rd("line ctrl", OFS_LINE_CTRL, 32'h0);
    expect_rd("flags", OFS_ERR_FLAGS, 32'h0);
    expect_rd("irq enable", OFS_ERR_IRQ_EN, 32'h0);
    reg_wr(8'h14, 32'hffffffff);
    expect_rd("unmapped", 8'h14, 32'h0);
    expect_rd("line after unmapped", OFS_LINE_CTRL, 32'h0);
    check("outputs idle", 32'h0, {23'h0, line_o, pkt_reject, irq});
  endtask

  // Software owns the pulls; the hardware request is opposite to the 0x54 pulls and equal to the 0xaf ones.
  task automatic t_sw_own();
    logic [31:0] v [3] = '{32'hffffffff, 32'h00000054, 32'h000000af};
    set_pull(4'ha, 1'b0);
    foreach (v[i]) begin
      reg_wr(OFS_LINE_CTRL, v[i]);
      @(posedge clk);
      #1 check("line outputs", {25'h0, v[i][7:3], v[i][1:0]}, {25'h0, line_o});
      check("vbus paths", {30'h0, v[i][1:0]}, {30'h0, line_o[1:0]});
      expect_rd("line readback", OFS_LINE_CTRL, {24'h0, v[i][7:0]});
    end
  endtask

  // Hardware owns the pulls while bit 2 is clear.
  task automatic t_hw_own();
    set_pull(4'ha, 1'b0);
    reg_wr(OFS_LINE_CTRL, 32'h0000000b);
    @(posedge clk);
    #1 check("hw pulls", 32'h57, {25'h0, line_o});
    expect_rd("hw readback", OFS_LINE_CTRL, 32'h000000ab);
    set_pull(4'h5, 1'b0);
    repeat (2) @(posedge clk);
    #1 check("hw pulls follow", 32'h2f, {25'h0, line_o});
    reg_wr(OFS_LINE_CTRL, 32'h0);
  endtask

  // Every event in device mode, cleared in turn by the flag register and the clear register.
  task automatic t_events();
    logic [7:0] m [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
    logic [7:0] f [8] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};
    for (int i = 0; i < 8; i++) begin
      i_peer.pulse(m[i]);
      #1 check("reject", {31'h0, f[i][7] | f[i][2]}, {31'h0, pkt_reject});
      expect_rd("event flag", OFS_ERR_FLAGS, {24'h0, f[i]});
      reg_wr(i[0] ? OFS_ERR_CLR : OFS_ERR_FLAGS, 32'hffffffff);
      expect_rd("cleared", OFS_ERR_FLAGS, 32'h0);
    end
  endtask

  // Flags stay set, ignore written zeros, and clear bit by bit.
  task automatic t_sticky();
    i_peer.pulse(8'h08);
    i_peer.pulse(8'h02);
    i_peer.pulse(8'h08);
    reg_wr(OFS_ERR_FLAGS, 32'h0);
    expect_rd("sticky", OFS_ERR_FLAGS, 32'h05);
    reg_wr(OFS_ERR_CLR, 32'h04);
    expect_rd("one cleared", OFS_ERR_FLAGS, 32'h01);
    expect_rd("clear reg reads zero", OFS_ERR_CLR, 32'h0);
    reg_wr(OFS_ERR_FLAGS, 32'h01);
  endtask

  // Host mode: frame-end flag only with a busy transfer.
  task automatic t_host();
    reg_wr(OFS_MODE, 32'h1);
    i_peer.pulse(8'h06);
    i_peer.pulse(8'h01);
    expect_rd("host idle", OFS_ERR_FLAGS, 32'h0);
    set_pull(4'h0, 1'b1);
    i_peer.pulse(8'h01);
    expect_rd("frame end", OFS_ERR_FLAGS, 32'h02);
    set_pull(4'h0, 1'b0);
    reg_wr(OFS_ERR_FLAGS, 32'h02);
    reg_wr(OFS_MODE, 32'h0);
  endtask

  // Turnaround: the limit itself passes, one more tick fires.
  task automatic t_turn();
    i_peer.ta_run(TA_LIM, 1'b1, TA_LIM + 1);
    @(posedge clk);
    expect_rd("answered", OFS_ERR_FLAGS, 32'h0);
    i_peer.ta_run(TA_LIM + 1, 1'b0, 0);
    @(posedge clk);
    expect_rd("timeout", OFS_ERR_FLAGS, 32'h10);
    reg_wr(OFS_ERR_FLAGS, 32'h10);
  endtask

  // Interrupt: masked event, enabled event, then clear.
  task automatic t_irq();
    reg_wr(OFS_ERR_IRQ_EN, 32'h04);
    expect_rd("irq enable", OFS_ERR_IRQ_EN, 32'h04);
    i_peer.pulse(8'h02);
    @(posedge clk);
    #1 check("irq masked", 32'h0, {31'h0, irq});
    i_peer.pulse(8'h08);
    @(posedge clk);
    #1 check("irq raised", 32'h1, {31'h0, irq});
    reg_wr(OFS_ERR_CLR, 32'h05);
    @(posedge clk);
    #1 check("irq dropped", 32'h0, {31'h0, irq});
  endtask

  // ------------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_sw_own();
    t_hw_own();
    t_events();
    t_sticky();
    t_host();
    t_turn();
    t_irq();
    test_done();
  end

  // The tests need well under a thousand cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH watchdog expected done seen hang");
    test_done();
  end
endmodule

// ===== bench/usbol_peer.sv
// Behavioural USB engine and cable peer that feeds packet events and turnaround timing.
`timescale 1ns/1ps

module usbol_peer
  import usbol_pkg::*;
(
  // Clock.
  input  wire logic clk,
  // Requests towards the block.
  output usbol_evt_s  evt,
  output usbol_ta_s   ta
);
  // ------------------------------------------------------------------
  // Idle levels
  // ------------------------------------------------------------------
  // Everything starts quiet so that no event is seen during reset.
  initial begin
    evt = '0;
    ta = '0;
  end

  // ------------------------------------------------------------------
  // Requests
  // ------------------------------------------------------------------
  // Events are one-cycle pulses, as the engine raises them.
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    evt <= m;
    @(posedge clk);
    evt <= '0;
  endtask

  // One tick a bit-time, with an idle cycle between ticks.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      ta.bit_tick <= 1'b1;
      @(posedge clk);
      ta.bit_tick <= 1'b0;
    end
  endtask

  // End of packet, idle bit-times, an optional answer, more idle.
  task automatic ta_run(input int n1, input logic resp, input int n2);
    @(posedge clk);
    ta.eop_done <= 1'b1;
    ta.await_resp <= 1'b1;
    @(posedge clk);
    ta.eop_done <= 1'b0;
    ticks(n1);
    if (resp) begin
      @(posedge clk);
      ta.resp_start <= 1'b1;
      ta.await_resp <= 1'b0;
      @(posedge clk);
      ta.resp_start <= 1'b0;
    end
    ticks(n2);
    ta.await_resp <= 1'b0;
  endtask
endmodule

// ===== rtl/usbol_pkg.sv
// Shared constants and types for the USB line control and error flag block.
package usbol_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  OFS_LINE_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_ERR_FLAGS    = 8'h04;
  localparam logic [7:0]  OFS_ERR_IRQ_EN   = 8'h08;
  localparam logic [7:0]  OFS_ERR_CLR      = 8'h0c;
  localparam logic [7:0]  OFS_MODE         = 8'h10;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_LINE_CTRL    = 8'h00;
  localparam logic [7:0]  RST_ERR_FLAGS    = 8'h00;
  localparam logic [7:0]  RST_ERR_IRQ_EN   = 8'h00;
  localparam logic        RST_HOST_MODE    = 1'b0;

  // ----------------------------------------------------------------------
  // Line control field positions
  // ----------------------------------------------------------------------
  localparam int          BIT_DP_PULLUP    = 7;
  localparam int          BIT_DM_PULLUP    = 6;
  localparam int          BIT_DP_PULLDN    = 5;
  localparam int          BIT_DM_PULLDN    = 4;
  localparam int          BIT_VBUS_ON      = 3;
  localparam int          BIT_SW_OWN       = 2;
  localparam int          BIT_VBUS_CHG     = 1;
  localparam int          BIT_VBUS_DIS     = 0;
  localparam int          BIT_HOST_MODE    = 0;

  // ----------------------------------------------------------------------
  // Error flag field positions
  // ----------------------------------------------------------------------
  localparam int          BIT_STUFF_ERR    = 7;
  localparam int          BIT_DESC_ADDR    = 6;
  localparam int          BIT_BUF_FETCH    = 5;
  localparam int          BIT_TURNAROUND   = 4;
  localparam int          BIT_PARTIAL      = 3;
  localparam int          BIT_DATA_CHECK   = 2;
  localparam int          BIT_TOKEN_FRAME  = 1;
  localparam int          BIT_PACKET_ID    = 0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int          TA_BIT_TIMES     = 16;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic dp_up;
    logic dm_up;
    logic dp_dn;
    logic dm_dn;
  } usbol_pull_s;

  typedef struct packed {
    logic stuff_err;
    logic addr_err;
    logic fetch_err;
    logic partial_byte;
    logic crc16_err;
    logic crc5_err;
    logic pid_err;
    logic sof_zero;
  } usbol_evt_s;

  typedef struct packed {
    logic eop_done;
    logic await_resp;
    logic resp_start;
    logic bit_tick;
  } usbol_ta_s;

  typedef enum logic [1:0] {
    TA_IDLE = 2'b01,
    TA_WAIT = 2'b10
  } usbol_ta_e;

endpackage

// ===== rtl/usbol_top.sv
// Line pull and VBUS control plus sticky error flags of a USB on-the-go port.
`timescale 1ns/1ps

module usbol_top
  import usbol_pkg::*;
#(
  parameter int TA_LIMIT = TA_BIT_TIMES
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Register port.
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wr_data,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [31:0]       rd_data,
  // Events and pull requests from the USB engine.
  input  wire usbol_pull_s       hw_pull,
  input  wire usbol_evt_s        evt,
  input  wire usbol_ta_s         ta,
  input  wire logic              xfer_busy,
  // Line and VBUS controls.
  output logic                   dplus_pullup_en,
  output logic                   dminus_pullup_en,
  output logic                   dplus_pulldown_en,
  output logic                   dminus_pulldown_en,
  output logic                   vbus_power_on,
  output logic                   vbus_charge_en,
  output logic                   vbus_discharge_en,
  // Packet rejection and interrupt.
  output logic                   pkt_reject,
  output logic                   irq
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  localparam int CW = $clog2(TA_LIMIT + 2);

  if (TA_LIMIT < 1) begin : g_bad_limit
    $error("TA_LIMIT must be at least one bit-time");
  end

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [7:0]    ctrl_r;
  logic [7:0]    ctrl_nxt;
  logic [7:0]    flags_r;
  logic [7:0]    flags_nxt;
  logic [7:0]    irq_en_r;
  logic [7:0]    irq_en_nxt;
  logic          host_mode_r;
  logic          host_mode_nxt;
  logic [31:0]   rd_nxt;
  usbol_ta_e     ta_state_r;
  usbol_ta_e     ta_state_nxt;
  logic [CW-1:0] ta_cnt_r;
  logic [CW-1:0] ta_cnt_nxt;

  // Address decode of the register port.
  logic wr_ctrl;
  logic wr_flags;
  logic wr_en;
  logic wr_clr;
  logic wr_mode;
  logic sw_own;
  logic [7:0] clr_vec;
  logic [7:0] set_vec;
  logic [3:0] pull_sel;
  logic [7:0] ctrl_view;
  logic       ta_fire;

  assign wr_ctrl  = wr_stb && (addr == OFS_LINE_CTRL);
  assign wr_flags = wr_stb && (addr == OFS_ERR_FLAGS);
  assign wr_en    = wr_stb && (addr == OFS_ERR_IRQ_EN);
  assign wr_clr   = wr_stb && (addr == OFS_ERR_CLR);
  assign wr_mode  = wr_stb && (addr == OFS_MODE);

  // ----------------------------------------------------------------------
  // Line pulls and VBUS
  // ----------------------------------------------------------------------
  // The ownership bit picks the pull source; in hardware ownership the
  // software copy is kept so that handing back ownership is glitch free.
  assign sw_own   = ctrl_r[BIT_SW_OWN];
  assign pull_sel = sw_own ? ctrl_r[BIT_DP_PULLUP:BIT_DM_PULLDN]
                           : {hw_pull.dp_up, hw_pull.dm_up,
                              hw_pull.dp_dn, hw_pull.dm_dn};

  // Software reads back the pull values currently in effect.
  assign ctrl_view = {pull_sel, ctrl_r[BIT_VBUS_ON:BIT_VBUS_DIS]};
  assign ctrl_nxt  = wr_ctrl ? wr_data[7:0] : ctrl_r;

  // Outputs are flopped, so pins change one cycle after the register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r             <= RST_LINE_CTRL;
      dplus_pullup_en    <= 1'b0;
      dminus_pullup_en   <= 1'b0;
      dplus_pulldown_en  <= 1'b0;
      dminus_pulldown_en <= 1'b0;
      vbus_power_on      <= 1'b0;
      vbus_charge_en     <= 1'b0;
      vbus_discharge_en  <= 1'b0;
    end else begin
      ctrl_r             <= ctrl_nxt;
      dplus_pullup_en    <= pull_sel[3];
      dminus_pullup_en   <= pull_sel[2];
      dplus_pulldown_en  <= pull_sel[1];
      dminus_pulldown_en <= pull_sel[0];
      vbus_power_on      <= ctrl_r[BIT_VBUS_ON];
      vbus_charge_en     <= ctrl_r[BIT_VBUS_CHG];
      vbus_discharge_en  <= ctrl_r[BIT_VBUS_DIS];
    end
  end

  // ----------------------------------------------------------------------
  // Bus turnaround watchdog
  // ----------------------------------------------------------------------
  // Counts bit-times after an end-of-packet that expects an answer; the
  // tick that makes the count exceed the limit raises the timeout.
  assign ta_fire = (ta_state_r == TA_WAIT) && !ta.resp_start && ta.bit_tick &&
                   (ta_cnt_r == CW'(TA_LIMIT));

  always_comb begin
    ta_state_nxt = ta_state_r;
    ta_cnt_nxt   = ta_cnt_r;
    case (ta_state_r)
      TA_IDLE: begin
        if (ta.eop_done && ta.await_resp) begin
          ta_state_nxt = TA_WAIT;
          ta_cnt_nxt   = '0;
        end
      end
      TA_WAIT: begin
        if (ta.resp_start || ta_fire) begin
          ta_state_nxt = TA_IDLE;
          ta_cnt_nxt   = '0;
        end else if (ta.bit_tick) begin
          ta_cnt_nxt   = ta_cnt_r + CW'(1);
        end
      end
      default: begin
        ta_state_nxt = TA_IDLE;
        ta_cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ta_state_r <= TA_IDLE;
      ta_cnt_r   <= '0;
    end else begin
      ta_state_r <= ta_state_nxt;
      ta_cnt_r   <= ta_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Error flags and interrupt
  // ----------------------------------------------------------------------
  // Bit 1 changes meaning with the role: frame overrun as host, token
  // check failure as device.
  assign set_vec[BIT_STUFF_ERR]   = evt.stuff_err;
  assign set_vec[BIT_DESC_ADDR]   = evt.addr_err;
  assign set_vec[BIT_BUF_FETCH]   = evt.fetch_err;
  assign set_vec[BIT_TURNAROUND]  = ta_fire;
  assign set_vec[BIT_PARTIAL]     = evt.partial_byte;
  assign set_vec[BIT_DATA_CHECK]  = evt.crc16_err;
  assign set_vec[BIT_TOKEN_FRAME] = host_mode_r ? (evt.sof_zero && xfer_busy)
                                                : evt.crc5_err;
  assign set_vec[BIT_PACKET_ID]   = !host_mode_r && evt.pid_err;

  // Both the flag register and the clear register accept ones to clear.
  assign clr_vec = (wr_flags || wr_clr) ? wr_data[7:0] : 8'h00;

  // A new event in the clearing cycle wins, so no error is lost.
  assign flags_nxt     = (flags_r & ~clr_vec) | set_vec;
  assign irq_en_nxt    = wr_en ? wr_data[7:0] : irq_en_r;
  assign host_mode_nxt = wr_mode ? wr_data[BIT_HOST_MODE] : host_mode_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r     <= RST_ERR_FLAGS;
      irq_en_r    <= RST_ERR_IRQ_EN;
      host_mode_r <= RST_HOST_MODE;
      irq         <= 1'b0;
      pkt_reject  <= 1'b0;
    end else begin
      flags_r     <= flags_nxt;
      irq_en_r    <= irq_en_nxt;
      host_mode_r <= host_mode_nxt;
      irq         <= |(flags_r & irq_en_r);
      pkt_reject  <= evt.crc16_err || evt.stuff_err;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Unmapped addresses and the clear register read as zero.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (rd_stb) begin
      case (addr)
        OFS_LINE_CTRL:  rd_nxt = {24'h00_0000, ctrl_view};
        OFS_ERR_FLAGS:  rd_nxt = {24'h00_0000, flags_r};
        OFS_ERR_IRQ_EN: rd_nxt = {24'h00_0000, irq_en_r};
        OFS_MODE:       rd_nxt = {31'h0000_0000, host_mode_r};
        default:        rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_sw_pullup;
    ctrl_r[BIT_SW_OWN] |=> (dplus_pullup_en == $past(ctrl_r[BIT_DP_PULLUP])) &&
                           (dminus_pullup_en == $past(ctrl_r[BIT_DM_PULLUP]));
  endproperty
  a_sw_pullup: assert property (p_sw_pullup) else $error("pull-up not software");

  property p_sw_pulldn;
    ctrl_r[BIT_SW_OWN] && !ctrl_r[BIT_DP_PULLDN] && !ctrl_r[BIT_DM_PULLDN]
      |=> !dplus_pulldown_en && !dminus_pulldown_en;
  endproperty
  a_sw_pulldn: assert property (p_sw_pulldn) else $error("pull-down stuck on");

  property p_hw_pull;
    !ctrl_r[BIT_SW_OWN] |=> ({dplus_pullup_en, dminus_pullup_en,
                              dplus_pulldown_en, dminus_pulldown_en} == $past(hw_pull));
  endproperty
  a_hw_pull: assert property (p_hw_pull) else $error("hardware pulls not followed");

  property p_vbus_on;
    wr_ctrl ##1 1'b1 |=> vbus_power_on == $past(wr_data[BIT_VBUS_ON], 2);
  endproperty
  a_vbus_on: assert property (p_vbus_on) else $error("VBUS power late");

  property p_vbus_paths;
    (vbus_charge_en == $past(ctrl_r[BIT_VBUS_CHG])) &&
    (vbus_discharge_en == $past(ctrl_r[BIT_VBUS_DIS]));
  endproperty
  a_vbus_paths: assert property (p_vbus_paths) else $error("VBUS path mismatch");

  property p_upper_zero;
    rd_stb |=> rd_data[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

  property p_sticky;
    1'b1 |=> ((($past(flags_r) & ~$past(clr_vec)) & ~flags_r) == 8'h00);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  property p_stuff_set;
    evt.stuff_err |=> flags_r[BIT_STUFF_ERR] && pkt_reject;
  endproperty
  a_stuff_set: assert property (p_stuff_set) else $error("stuff flag missed");

  property p_crc16;
    evt.crc16_err |=> flags_r[BIT_DATA_CHECK] && pkt_reject;
  endproperty
  a_crc16: assert property (p_crc16) else $error("data check flag missed");

  property p_turnaround;
    ta_fire |=> flags_r[BIT_TURNAROUND] && (ta_state_r == TA_IDLE);
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("timeout flag missed");

  property p_ta_bound;
    (ta_state_r == TA_WAIT) |-> ta_cnt_r <= CW'(TA_LIMIT);
  endproperty
  a_ta_bound: assert property (p_ta_bound) else $error("turnaround count overrun");

  property p_frame_end;
    host_mode_r && evt.sof_zero && xfer_busy |=> flags_r[BIT_TOKEN_FRAME];
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame end flag missed");

  property p_irq;
    (|(flags_r & irq_en_r)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  // A masked or empty status must keep the interrupt low.
  property p_irq_low;
    !(|(flags_r & irq_en_r)) |=> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt without cause");

  property p_sw_pulldn_on;
    ctrl_r[BIT_SW_OWN] |=> (dplus_pulldown_en == $past(ctrl_r[BIT_DP_PULLDN])) &&
                           (dminus_pulldown_en == $past(ctrl_r[BIT_DM_PULLDN]));
  endproperty
  a_sw_pulldn_on: assert property (p_sw_pulldn_on) else $error("pull-down wrong");

  property p_reject_only;
    !evt.crc16_err && !evt.stuff_err |=> !pkt_reject;
  endproperty
  a_reject_only: assert property (p_reject_only) else $error("spurious reject");

  property p_addr_err;
    evt.addr_err |=> flags_r[BIT_DESC_ADDR];
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("address flag missed");

  property p_fetch_err;
    evt.fetch_err |=> flags_r[BIT_BUF_FETCH];
  endproperty
  a_fetch_err: assert property (p_fetch_err) else $error("fetch flag missed");

  property p_partial;
    evt.partial_byte |=> flags_r[BIT_PARTIAL];
  endproperty
  a_partial: assert property (p_partial) else $error("partial byte flag missed");

  // In device mode bits 1 and 0 report the token and packet id checks.
  property p_dev_checks;
    !host_mode_r |=> (flags_r[BIT_TOKEN_FRAME] || !$past(evt.crc5_err)) &&
                     (flags_r[BIT_PACKET_ID] || !$past(evt.pid_err));
  endproperty
  a_dev_checks: assert property (p_dev_checks) else $error("device check flag missed");

  // A written one clears its bit unless an event sets it in the same cycle.
  property p_clear_bits;
    (wr_flags || wr_clr) |=> (flags_r & $past(wr_data[7:0] & ~set_vec)) == 8'h00;
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("flag not cleared");

  property p_set_by_hw;
    1'b1 |=> (flags_r & ~$past(flags_r) & ~$past(set_vec)) == 8'h00;
  endproperty
  a_set_by_hw: assert property (p_set_by_hw) else $error("flag set without event");

  property p_ta_start;
    (ta_state_r == TA_IDLE) && ta.eop_done && ta.await_resp
      |=> (ta_state_r == TA_WAIT) && (ta_cnt_r == '0);
  endproperty
  a_ta_start: assert property (p_ta_start) else $error("turnaround wait not started");

  c_timeout: cover property (ta_fire);
  c_clear:   cover property (wr_clr ##1 flags_r == 8'h00);
  c_handoff: cover property (ctrl_r[BIT_SW_OWN] ##1 !ctrl_r[BIT_SW_OWN]);
  c_irq:     cover property (!irq ##1 irq);
  c_frame_end: cover property (host_mode_r && evt.sof_zero && xfer_busy);

endmodule
